// [logic/ssr_ppoll.sv]
// parallel poll configuration and response drive
// assumes configure, enable and poll strobes come from bus logic on core_clk
`timescale 1ns/1ps
module ssr_ppoll
  import ssr_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ppc_cmd,
  input wire logic ppe_cmd,
  input wire logic [7:0] ppe_byte,
  input wire logic ppu_cmd,
  input wire logic poll_active,
  input wire logic ist,
  output logic pp_armed,
  output logic [7:0] pp_dio_out,
  output logic [7:0] pp_dio_oe
);
  ssr_pp_state_t state;
  logic sense;
  logic [2:0] line;
  logic ppe_ok;

  // bit 7 is a don't care
  assign ppe_ok = ppe_byte[6:SSR_PPE_KEY_LSB] == SSR_PPE_KEY;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SSR_PP_IDLE;
      sense <= 1'b0;
      line <= 3'h0;
    end else if (ppu_cmd) begin
      state <= SSR_PP_IDLE;
    end else begin
      case (state)
        SSR_PP_IDLE: begin
          if (ppc_cmd) begin
            state <= SSR_PP_CFG;
          end
        end
        SSR_PP_CFG, SSR_PP_ARMED: begin
          if (ppe_cmd && ppe_ok) begin
            state <= SSR_PP_ARMED;
            sense <= ppe_byte[SSR_PPE_SENSE];
            line <= ppe_byte[2:0];
          end else if (ppe_cmd) begin
            state <= SSR_PP_IDLE;
          end
        end
        default: state <= SSR_PP_IDLE;
      endcase
    end
  end

  assign pp_armed = state == SSR_PP_ARMED;

  // lines are passively terminated, so only a true answer drives its line
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pp_dio_out <= 8'h00;
      pp_dio_oe <= 8'h00;
    end else if (poll_active && pp_armed && (ist == sense)) begin
      pp_dio_out <= 8'h01 << line;
      pp_dio_oe <= 8'h01 << line;
    end else begin
      pp_dio_out <= 8'h00;
      pp_dio_oe <= 8'h00;
    end
  end

  a_ppe_decode: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(pp_armed) |-> $past(ppe_cmd) && $past(ppe_byte[6:4]) == 3'h6)
    else $error("poll armed by a bad enable byte");
endmodule

// [logic/ssr_qerr_det.sv]
// detects unterminated, interrupted and deadlock query errors
// assumes parser, formatter and queue status arrive on core_clk
`timescale 1ns/1ps
module ssr_qerr_det
  import ssr_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic talk_addressed,
  input wire logic fmt_idle,
  input wire logic fmt_waiting,
  input wire logic queue_empty,
  input wire logic queue_full,
  input wire logic term_read,
  input wire logic multi_end,
  ssr_qerr_if.det q
);
  logic talk_q;
  logic intr_q;
  logic dead_q;
  logic intr_cond;
  logic dead_cond;

  // edges only, so a lingering condition raises a single error
  assign intr_cond = fmt_waiting && (term_read || multi_end);
  assign dead_cond = fmt_waiting && queue_full;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      talk_q <= 1'b0;
      intr_q <= 1'b0;
      dead_q <= 1'b0;
    end else begin
      talk_q <= talk_addressed;
      intr_q <= intr_cond;
      dead_q <= dead_cond;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q.unterm <= 1'b0;
      q.intr <= 1'b0;
      q.dead <= 1'b0;
    end else begin
      q.unterm <= talk_addressed && !talk_q && fmt_idle && queue_empty;
      q.intr <= intr_cond && !intr_q;
      q.dead <= dead_cond && !dead_q;
    end
  end

  a_unterm_cause: assert property (@(posedge core_clk) disable iff (!arst_n)
    q.unterm |-> $past(fmt_idle) && $past(queue_empty) && $past(talk_addressed))
    else $error("unterminated error without its cause");
endmodule

// [logic/ssr_status_top.sv]
// status and error reporting unit: event flags, masks, status byte, query errors, parallel poll
// assumes commands, parser, formatter and queue status all come from logic on core_clk
//
// Notes on behaviour
// - talk request with idle formatter and empty queue: query error, code 3, parser reset.
// - pending response plus terminator or several end markers: query error, code 1.
// - pending response and queue fills: deadlock, query error, code 2.
// - after interrupted or deadlock, reset formatter, drop output, parser carries on.
// - poll status bit is one when poll mask AND status byte is nonzero.
// - poll enable byte: bit 7 ignored, bits 6..4 are 110, sense bit 3, line 2..0.
// - event summary bit 5 set when an enabled event flag is set.
// - event flag query returns the flags and clears them together.
// - event flag bit 7 set at power on.
// - syntax error sets flag bit 5 and resets the parser.
// - execution failure sets flag bit 4 and records its error number.
// - any query error sets flag bit 2; code 1, 2 or 3.
// - operation-complete command sets flag bit 0.
// - enabled status bit sets status bit 6 and raises service request.
// - status query gives summary in bit 6, serial poll gives requesting-service flag.
// - message available bit set when response ready, cleared after terminator sent.
// - event mask is written by set command and read back by query.
// - service request mask is written by set command and read back by query.
// - poll enable mask is written by set command and read back by query.
`timescale 1ns/1ps
module ssr_status_top
  import ssr_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire ssr_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic talk_addressed,
  input wire logic fmt_idle,
  input wire logic fmt_waiting,
  input wire logic queue_empty,
  input wire logic queue_full,
  input wire logic term_read,
  input wire logic multi_end,
  input wire logic syntax_error,
  input wire logic exec_error,
  input wire logic [7:0] exec_error_code,
  input wire logic opc_cmd,
  input wire logic response_ready,
  input wire logic terminator_sent,
  input wire logic ppc_cmd,
  input wire logic ppe_cmd,
  input wire logic [7:0] ppe_byte,
  input wire logic ppu_cmd,
  input wire logic poll_active,
  output logic parser_reset,
  output logic formatter_reset,
  output logic [7:0] query_error_code,
  output logic [7:0] exec_error_number,
  output logic service_request,
  output logic ist,
  output logic pp_armed,
  output logic [7:0] pp_dio_out,
  output logic [7:0] pp_dio_oe
);
  ssr_qerr_if qe ();

  logic [7:0] standard_event_flags;
  logic [7:0] standard_event_mask;
  logic [7:0] service_request_mask;
  logic [7:0] poll_enable_mask;
  logic message_available_bit;
  logic service_request_summary_bit;
  logic requesting_service;
  logic event_summary_bit;
  logic [7:0] status_summary_byte;
  logic [7:0] next_flags;
  logic [7:0] flag_sets;
  logic query_error;
  logic flags_read;
  logic spoll_read;
  logic mss_q;

  ssr_qerr_det u_det (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .talk_addressed(talk_addressed),
    .fmt_idle(fmt_idle),
    .fmt_waiting(fmt_waiting),
    .queue_empty(queue_empty),
    .queue_full(queue_full),
    .term_read(term_read),
    .multi_end(multi_end),
    .q(qe.det)
  );

  ssr_ppoll u_pp (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ppc_cmd(ppc_cmd),
    .ppe_cmd(ppe_cmd),
    .ppe_byte(ppe_byte),
    .ppu_cmd(ppu_cmd),
    .poll_active(poll_active),
    .ist(ist),
    .pp_armed(pp_armed),
    .pp_dio_out(pp_dio_out),
    .pp_dio_oe(pp_dio_oe)
  );

  assign query_error = qe.unterm || qe.intr || qe.dead;
  assign flags_read = cmd_valid && (cmd_op == SSR_OP_ESR_Q);
  assign spoll_read = cmd_valid && (cmd_op == SSR_OP_SPOLL);

  // hardware sets win over the read-clear of the same cycle
  always_comb begin
    flag_sets = 8'h00;
    flag_sets[SSR_EV_CMD] = syntax_error;
    flag_sets[SSR_EV_EXE] = exec_error;
    flag_sets[SSR_EV_QRY] = query_error;
    flag_sets[SSR_EV_OPC] = opc_cmd;
    next_flags = (flags_read ? 8'h00 : standard_event_flags) | flag_sets;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      standard_event_flags <= SSR_ESR_RESET;
    end else begin
      standard_event_flags <= next_flags & SSR_ESR_USED;
    end
  end

  // error registers hold the last code until power cycles
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      query_error_code <= SSR_ERR_RESET;
    end else if (qe.intr) begin
      query_error_code <= SSR_QE_INTERRUPTED;
    end else if (qe.dead) begin
      query_error_code <= SSR_QE_DEADLOCK;
    end else if (qe.unterm) begin
      query_error_code <= SSR_QE_UNTERMINATED;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      exec_error_number <= SSR_ERR_RESET;
    end else if (exec_error) begin
      exec_error_number <= exec_error_code;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      parser_reset <= 1'b0;
      formatter_reset <= 1'b0;
    end else begin
      parser_reset <= qe.unterm || syntax_error;
      formatter_reset <= qe.intr || qe.dead;
    end
  end

  // masks written by set commands
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      standard_event_mask <= SSR_MASK_RESET;
      service_request_mask <= SSR_MASK_RESET;
      poll_enable_mask <= SSR_MASK_RESET;
    end else if (cmd_valid) begin
      case (cmd_op)
        SSR_OP_ESE_SET: standard_event_mask <= cmd_data;
        SSR_OP_SRE_SET: service_request_mask <= cmd_data;
        SSR_OP_PRE_SET: poll_enable_mask <= cmd_data;
        default: begin
        end
      endcase
    end
  end

  // a discarded response is no longer available
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      message_available_bit <= 1'b0;
    end else if (response_ready) begin
      message_available_bit <= 1'b1;
    end else if (terminator_sent || formatter_reset) begin
      message_available_bit <= 1'b0;
    end
  end

  assign event_summary_bit = |(standard_event_flags & standard_event_mask);

  // bit 6 of the mask cannot enable itself
  assign service_request_summary_bit = |({2'b00, event_summary_bit, message_available_bit, 4'h0}
    & service_request_mask & SSR_STB_USED & ~8'h40);

  always_comb begin
    status_summary_byte = 8'h00;
    status_summary_byte[SSR_SB_RQS] = service_request_summary_bit;
    status_summary_byte[SSR_SB_ESB] = event_summary_bit;
    status_summary_byte[SSR_SB_MAV] = message_available_bit;
  end

  // requesting service latches on a new summary and drops after being polled or when the summary clears
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mss_q <= 1'b0;
      requesting_service <= 1'b0;
    end else begin
      mss_q <= service_request_summary_bit;
      if (service_request_summary_bit && !mss_q) begin
        requesting_service <= 1'b1;
      end else if (spoll_read || !service_request_summary_bit) begin
        requesting_service <= 1'b0;
      end
    end
  end

  assign service_request = requesting_service;
  assign ist = |(poll_enable_mask & status_summary_byte);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      if (cmd_valid) begin
        case (cmd_op)
          SSR_OP_ESR_Q: begin
            rsp_valid <= 1'b1;
            rsp_data <= standard_event_flags;
          end
          SSR_OP_ESE_Q: begin
            rsp_valid <= 1'b1;
            rsp_data <= standard_event_mask;
          end
          SSR_OP_SRE_Q: begin
            rsp_valid <= 1'b1;
            rsp_data <= service_request_mask;
          end
          SSR_OP_PRE_Q: begin
            rsp_valid <= 1'b1;
            rsp_data <= poll_enable_mask;
          end
          SSR_OP_STB_Q: begin
            rsp_valid <= 1'b1;
            rsp_data <= status_summary_byte;
          end
          SSR_OP_SPOLL: begin
            rsp_valid <= 1'b1;
            rsp_data <= {1'b0, requesting_service, status_summary_byte[5:0]};
          end
          default: begin
          end
        endcase
      end
    end
  end

  a_unterm_code: assert property (@(posedge core_clk) disable iff (!arst_n)
    qe.unterm && !qe.intr && !qe.dead |=> query_error_code == 8'h03 && standard_event_flags[2])
    else $error("unterminated error not recorded");

  a_intr_code: assert property (@(posedge core_clk) disable iff (!arst_n)
    qe.intr |=> query_error_code == 8'h01 && formatter_reset)
    else $error("interrupted error not recorded");

  a_dead_code: assert property (@(posedge core_clk) disable iff (!arst_n)
    qe.dead && !qe.intr |=> query_error_code == 8'h02)
    else $error("deadlock code not recorded");

  a_fmt_reset: assert property (@(posedge core_clk) disable iff (!arst_n)
    formatter_reset |-> $past(qe.intr) || $past(qe.dead))
    else $error("formatter reset without a query error");

  a_ist_value: assert property (@(posedge core_clk) disable iff (!arst_n)
    ist == (poll_enable_mask[6] && service_request_summary_bit || poll_enable_mask[5] && event_summary_bit
      || poll_enable_mask[4] && message_available_bit))
    else $error("poll status bit disagrees with masked status");

  a_esb_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
    standard_event_flags[0] && standard_event_mask[0] |-> status_summary_byte[5])
    else $error("event summary bit missing");

  a_flags_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    flags_read && !syntax_error && !exec_error && !query_error && !opc_cmd
    |=> standard_event_flags == 8'h00 && rsp_valid && rsp_data == $past(standard_event_flags))
    else $error("flag query did not return and clear");

  a_syntax_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    syntax_error |=> standard_event_flags[5] && parser_reset)
    else $error("syntax error not flagged");

  a_exec_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    exec_error |=> standard_event_flags[4] && exec_error_number == $past(exec_error_code))
    else $error("execution error not flagged");

  a_opc_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    opc_cmd |=> standard_event_flags[0])
    else $error("operation complete not flagged");

  a_srq_raise: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(service_request_summary_bit) |=> service_request)
    else $error("service request not raised");

  a_mav_track: assert property (@(posedge core_clk) disable iff (!arst_n)
    response_ready |=> message_available_bit ##0 status_summary_byte[4])
    else $error("message available not set");

  a_mask_rw: assert property (@(posedge core_clk) disable iff (!arst_n)
    cmd_valid && cmd_op == SSR_OP_SRE_SET ##1 !cmd_valid ##1 cmd_valid && cmd_op == SSR_OP_SRE_Q
    |=> rsp_data == $past(cmd_data, 3))
    else $error("service mask readback wrong");

  a_unused_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    (standard_event_flags & ~SSR_ESR_USED) == 8'h00 && (status_summary_byte & ~SSR_STB_USED) == 8'h00)
    else $error("unused status bit set");
endmodule

// [pkg/ssr_pkg.sv]
// constants, command codes and state types of the status and error reporting unit
// assumes a single core clock; shared by the top module and its two helpers
package ssr_pkg;

  // event flag register layout
  localparam logic [7:0] SSR_ESR_RESET = 8'h80;
  localparam logic [7:0] SSR_ESR_USED = 8'hb5;
  localparam int SSR_EV_PON = 7;
  localparam int SSR_EV_CMD = 5;
  localparam int SSR_EV_EXE = 4;
  localparam int SSR_EV_QRY = 2;
  localparam int SSR_EV_OPC = 0;

  // status byte layout
  localparam logic [7:0] SSR_STB_USED = 8'h70;
  localparam int SSR_SB_RQS = 6;
  localparam int SSR_SB_ESB = 5;
  localparam int SSR_SB_MAV = 4;

  // reset values of the masks and error registers
  localparam logic [7:0] SSR_MASK_RESET = 8'h00;
  localparam logic [7:0] SSR_ERR_RESET = 8'h00;

  // query error codes
  localparam logic [7:0] SSR_QE_INTERRUPTED = 8'h01;
  localparam logic [7:0] SSR_QE_DEADLOCK = 8'h02;
  localparam logic [7:0] SSR_QE_UNTERMINATED = 8'h03;

  // poll enable byte fields
  localparam logic [2:0] SSR_PPE_KEY = 3'h6;
  localparam int SSR_PPE_KEY_LSB = 4;
  localparam int SSR_PPE_SENSE = 3;

  typedef enum logic [3:0] {
    SSR_OP_ESR_Q,
    SSR_OP_ESE_SET,
    SSR_OP_ESE_Q,
    SSR_OP_SRE_SET,
    SSR_OP_SRE_Q,
    SSR_OP_STB_Q,
    SSR_OP_PRE_SET,
    SSR_OP_PRE_Q,
    SSR_OP_SPOLL
  } ssr_op_t;

  typedef enum logic [1:0] {
    SSR_PP_IDLE,
    SSR_PP_CFG,
    SSR_PP_ARMED
  } ssr_pp_state_t;

endpackage

// [pkg/ssr_qerr_if.sv]
// query error event pulses passed from the detector to the status core
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface ssr_qerr_if;
  logic unterm;
  logic intr;
  logic dead;
  modport det (output unterm, output intr, output dead);
  modport core (input unterm, input intr, input dead);
endinterface

// [testbench/ssr_gpib_ctrl.sv]
// bus controller model: common commands, poll configure/enable and parallel polls
// assumes the bench calls its tasks; signals change only at the falling edge
`timescale 1ns/1ps
module ssr_gpib_ctrl
  import ssr_pkg::*;
(
  input wire logic core_clk,
  output logic cmd_valid,
  output ssr_op_t cmd_op,
  output logic [7:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  output logic ppc_cmd,
  output logic ppe_cmd,
  output logic [7:0] ppe_byte,
  output logic ppu_cmd,
  output logic poll_active,
  input wire logic [7:0] pp_dio_out,
  input wire logic [7:0] pp_dio_oe
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = SSR_OP_STB_Q;
    cmd_data = 8'h00;
    ppc_cmd = 1'b0;
    ppe_cmd = 1'b0;
    ppe_byte = 8'h00;
    ppu_cmd = 1'b0;
    poll_active = 1'b0;
  end

  // released data lines show the inverse so a stale value is never mistaken for a live one
  task automatic xfer(input ssr_op_t op, input logic [7:0] data, input int gap,
                      output logic got, output logic [7:0] ans);
    repeat (gap) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = data;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_data = ~data;
    got = rsp_valid;
    ans = rsp_data;
  endtask

  // configure is sent first, then the enable byte; with_cfg=0 breaks that on purpose
  task automatic pp_config(input logic [7:0] b, input logic with_cfg);
    @(negedge core_clk);
    ppc_cmd = with_cfg;
    @(negedge core_clk);
    ppc_cmd = 1'b0;
    ppe_cmd = 1'b1;
    ppe_byte = b;
    @(negedge core_clk);
    ppe_cmd = 1'b0;
    ppe_byte = ~b;
  endtask

  task automatic pp_unconfig();
    @(negedge core_clk);
    ppu_cmd = 1'b1;
    @(negedge core_clk);
    ppu_cmd = 1'b0;
  endtask

  task automatic poll(output logic [7:0] dout, output logic [7:0] doe);
    @(negedge core_clk);
    poll_active = 1'b1;
    @(negedge core_clk);
    dout = pp_dio_out;
    doe = pp_dio_oe;
    poll_active = 1'b0;
  endtask
endmodule

// [testbench/test_ieee488_status_error_reporting.sv]
// self-checking bench of the status and error reporting unit
// assumes one 250 MHz clock; inputs change at the falling edge
`timescale 1ns/1ps
module test_ieee488_status_error_reporting
  import ssr_pkg::*;
;
  logic core_clk, arst_n, cmd_valid, rsp_valid, talk_addressed, fmt_idle, fmt_waiting;
  logic queue_empty, queue_full, term_read, multi_end, syntax_error, exec_error, opc_cmd;
  logic response_ready, terminator_sent, ppc_cmd, ppe_cmd, ppu_cmd, poll_active;
  logic parser_reset, formatter_reset, service_request, ist, pp_armed;
  logic [7:0] cmd_data, rsp_data, exec_error_code, ppe_byte, query_error_code;
  logic [7:0] exec_error_number, pp_dio_out, pp_dio_oe;
  ssr_op_t cmd_op;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;

  ssr_status_top u_ssr_status_top (.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .talk_addressed(talk_addressed), .fmt_idle(fmt_idle), .fmt_waiting(fmt_waiting),
    .queue_empty(queue_empty), .queue_full(queue_full), .term_read(term_read),
    .multi_end(multi_end), .syntax_error(syntax_error), .exec_error(exec_error),
    .exec_error_code(exec_error_code), .opc_cmd(opc_cmd), .response_ready(response_ready),
    .terminator_sent(terminator_sent), .ppc_cmd(ppc_cmd), .ppe_cmd(ppe_cmd),
    .ppe_byte(ppe_byte), .ppu_cmd(ppu_cmd), .poll_active(poll_active),
    .parser_reset(parser_reset), .formatter_reset(formatter_reset),
    .query_error_code(query_error_code), .exec_error_number(exec_error_number),
    .service_request(service_request), .ist(ist), .pp_armed(pp_armed),
    .pp_dio_out(pp_dio_out), .pp_dio_oe(pp_dio_oe));

  ssr_gpib_ctrl u_ssr_gpib_ctrl (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ppc_cmd(ppc_cmd),
    .ppe_cmd(ppe_cmd), .ppe_byte(ppe_byte), .ppu_cmd(ppu_cmd), .poll_active(poll_active),
    .pp_dio_out(pp_dio_out), .pp_dio_oe(pp_dio_oe));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // whole run is well under two hundred cycles; the ceiling leaves a wide margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic ask(input ssr_op_t op, input logic [7:0] exp);
    logic g;
    logic [7:0] a;
    u_ssr_gpib_ctrl.xfer(op, 8'h00, 0, g, a);
    check_bit(g, 1'b1);
    check_byte(a, exp);
  endtask

  task automatic put(input ssr_op_t op, input logic [7:0] d);
    logic g;
    logic [7:0] a;
    u_ssr_gpib_ctrl.xfer(op, d, 1, g, a);
    check_bit(g, 1'b0);
  endtask

  task automatic pulse(ref logic sig);
    @(negedge core_clk);
    sig = 1'b1;
    @(negedge core_clk);
    sig = 1'b0;
  endtask

  // cause was driven at the last falling edge; code and resets land two cycles on, for one cycle
  task automatic qerr_check(input logic [7:0] code, input logic unterm);
    @(negedge core_clk);
    term_read = 1'b0;
    @(negedge core_clk);
    check_byte(query_error_code, code);
    check_bit(parser_reset, unterm);
    check_bit(formatter_reset, !unterm);
    @(negedge core_clk);
    check_bit(parser_reset | formatter_reset, 1'b0);
    {talk_addressed, fmt_idle, queue_empty, fmt_waiting, queue_full, multi_end} = '0;
  endtask

  task automatic t_reset();
    ask(SSR_OP_ESR_Q, 8'h80);
    ask(SSR_OP_ESR_Q, 8'h00);
    ask(SSR_OP_ESE_Q, 8'h00);
    ask(SSR_OP_SRE_Q, 8'h00);
    ask(SSR_OP_PRE_Q, 8'h00);
    ask(SSR_OP_STB_Q, 8'h00);
    check_byte(query_error_code | exec_error_number, 8'h00);
  endtask

  task automatic t_events();
    pulse(opc_cmd);
    exec_error_code = 8'h5a;
    pulse(exec_error);
    exec_error_code = 8'ha5;
    pulse(syntax_error);
    check_bit(parser_reset, 1'b1);
    check_byte(exec_error_number, 8'h5a);
    put(SSR_OP_ESE_SET, 8'hff);
    ask(SSR_OP_ESE_Q, 8'hff);
    ask(SSR_OP_ESR_Q, 8'h31);
    ask(SSR_OP_ESR_Q, 8'h00);
  endtask

  task automatic t_service();
    put(SSR_OP_ESE_SET, 8'h01);
    pulse(opc_cmd);
    ask(SSR_OP_STB_Q, 8'h20);
    check_bit(service_request, 1'b0);
    put(SSR_OP_SRE_SET, 8'h20);
    ask(SSR_OP_SRE_Q, 8'h20);
    check_bit(service_request, 1'b1);
    ask(SSR_OP_STB_Q, 8'h60);
    ask(SSR_OP_SPOLL, 8'h60);
    ask(SSR_OP_SPOLL, 8'h20);
    ask(SSR_OP_STB_Q, 8'h60);
    ask(SSR_OP_ESR_Q, 8'h01);
    repeat (2) @(negedge core_clk);
    ask(SSR_OP_STB_Q, 8'h00);
    check_bit(service_request, 1'b0);
    put(SSR_OP_ESE_SET, 8'h00);
    put(SSR_OP_SRE_SET, 8'h00);
  endtask

  task automatic t_mav();
    pulse(response_ready);
    ask(SSR_OP_STB_Q, 8'h10);
    pulse(terminator_sent);
    ask(SSR_OP_STB_Q, 8'h00);
  endtask

  task automatic t_qerr();
    @(negedge core_clk);
    {fmt_idle, queue_empty, talk_addressed} = 3'h7;
    qerr_check(8'h03, 1'b1);
    pulse(response_ready);
    {fmt_waiting, term_read} = 2'h3;
    qerr_check(8'h01, 1'b0);
    ask(SSR_OP_STB_Q, 8'h00);
    @(negedge core_clk);
    {fmt_waiting, queue_full} = 2'h3;
    qerr_check(8'h02, 1'b0);
    @(negedge core_clk);
    {fmt_waiting, multi_end} = 2'h3;
    qerr_check(8'h01, 1'b0);
    ask(SSR_OP_ESR_Q, 8'h04);
  endtask

  task automatic t_ppoll();
    logic [7:0] o, e;
    put(SSR_OP_PRE_SET, 8'h10);
    ask(SSR_OP_PRE_Q, 8'h10);
    check_bit(ist, 1'b0);
    pulse(response_ready);
    check_bit(ist, 1'b1);
    u_ssr_gpib_ctrl.pp_config(8'he9, 1'b1);
    check_bit(pp_armed, 1'b1);
    u_ssr_gpib_ctrl.poll(o, e);
    check_byte(o & e, 8'h02);
    u_ssr_gpib_ctrl.pp_config(8'h61, 1'b1);
    u_ssr_gpib_ctrl.poll(o, e);
    check_byte(e, 8'h00);
    pulse(terminator_sent);
    check_bit(ist, 1'b0);
    u_ssr_gpib_ctrl.poll(o, e);
    check_byte(e, 8'h02);
    u_ssr_gpib_ctrl.pp_config(8'h29, 1'b1);
    check_bit(pp_armed, 1'b0);
    u_ssr_gpib_ctrl.pp_config(8'h69, 1'b0);
    check_bit(pp_armed, 1'b0);
    u_ssr_gpib_ctrl.pp_config(8'h69, 1'b1);
    check_bit(pp_armed, 1'b1);
    u_ssr_gpib_ctrl.pp_unconfig();
    check_bit(pp_armed, 1'b0);
  endtask

  initial begin
    arst_n = 1'b0;
    {talk_addressed, fmt_idle, fmt_waiting, queue_empty, queue_full, term_read} = '0;
    {multi_end, syntax_error, exec_error, opc_cmd, response_ready, terminator_sent} = '0;
    exec_error_code = 8'h00;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    t_reset();
    t_events();
    t_service();
    t_mav();
    t_qerr();
    t_ppoll();
    tally_and_finish();
  end
endmodule
